// ===== logic/satl_pkg.sv
// Shared constants for the secondary axle torque link
package satl_pkg;
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned MODE_DELAY_MS  = 30;
    localparam int unsigned SLOW_DELAY_MS  = 125;
    // Longest times, so cycle counts round down
    localparam int unsigned MODE_PERIOD_CYC = MODE_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned SLOW_PERIOD_CYC = SLOW_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned TIMER_W         = 22;

    // Field widths and scale factors
    localparam int unsigned DIFF_W   = 7;
    localparam int unsigned TORQUE_W = 10;
    localparam int unsigned CNT_W    = 2;
    localparam int unsigned PROT_W   = 11;
    localparam int unsigned PKT_W    = 11;
    localparam int unsigned DIFF_RPM_PER_CNT = 2;
    localparam int unsigned TORQUE_NM_PER_CNT = 10;

    // Control mode encoding
    localparam logic MODE_INTERNAL = 1'b0;
    localparam logic MODE_EXTERNAL = 1'b1;

    // Error filter defaults (real sizes defined elsewhere)
    localparam int unsigned WIN_X_DEF = 3;
    localparam int unsigned WIN_Y_DEF = 8;
    localparam logic [7:0]  PROT_KEY_DEF = 8'h5a;

    // Chassis register map, byte offsets
    localparam int unsigned ADDR_W   = 8;
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_REQUEST  = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    // CTRL fields
    localparam int unsigned CTRL_AWD_BIT      = 0;
    localparam int unsigned CTRL_BAD_PROT_BIT = 1;
    localparam int unsigned CTRL_HOLD_CNT_BIT = 2;
    localparam logic [2:0]  CTRL_RESET        = 3'h0;
    // REQUEST fields
    localparam int unsigned REQ_ACTIVE_BIT = 10;
    // STATUS fields
    localparam int unsigned ST_MODE_BIT    = 0;
    localparam int unsigned ST_DIFF_LSB    = 1;
    localparam int unsigned ST_DIFF_ACT_BIT = 8;
    localparam int unsigned ST_INHIBIT_BIT = 9;
    // Interrupt bits
    localparam int unsigned IRQ_W           = 3;
    localparam int unsigned IRQ_MODE_BIT    = 0;
    localparam int unsigned IRQ_INHIBIT_BIT = 1;
    localparam int unsigned IRQ_DIFF_BIT    = 2;

    // Protection value: 8-bit keyed checksum of the packet and count
    function automatic logic [PROT_W-1:0] satl_protect(input logic [PKT_W-1:0] pkt,
                                                       input logic [CNT_W-1:0] cnt,
                                                       input logic [7:0]       key);
        logic [7:0] sum;
        sum = pkt[7:0] + {5'h00, pkt[10:8]} + {6'h00, cnt} + key;
        return {3'h0, sum};
    endfunction
endpackage

// ===== logic/satl_if.sv
// Link between the transfer case controller and the chassis module
interface satl_if;
    import satl_pkg::*;
    logic                mode_valid;
    logic                mode_ext;
    logic                stat_valid;
    logic [DIFF_W-1:0]   diff_rpm;
    logic                diff_act;
    logic                inhibit;
    logic                req_valid;
    logic [TORQUE_W-1:0] req_torque;
    logic                req_act;
    logic [CNT_W-1:0]    req_cnt;
    logic [PROT_W-1:0]   req_prot;

    modport device (output mode_valid, mode_ext, stat_valid, diff_rpm, diff_act, inhibit,
                    input  req_valid, req_torque, req_act, req_cnt, req_prot);
    modport chassis (input  mode_valid, mode_ext, stat_valid, diff_rpm, diff_act, inhibit,
                     output req_valid, req_torque, req_act, req_cnt, req_prot);
endinterface

// ===== logic/satl_chassis.sv
// Chassis module end: sends torque requests, receives axle status
module satl_chassis #(
    parameter int unsigned SLOW_PERIOD = satl_pkg::SLOW_PERIOD_CYC,
    parameter logic [7:0]  PROT_KEY    = satl_pkg::PROT_KEY_DEF
) (
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    satl_if.chassis                        link,
    input  wire logic [satl_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [31:0]               wdata_in,
    input  wire logic                      wr_in,
    input  wire logic                      rd_in,
    output logic      [31:0]               rdata_out,
    output logic                           irq_out,
    output logic                           drive_off_lamp_out,
    output logic                           diff_limit_on_out,
    output logic      [satl_pkg::DIFF_W-1:0] diff_limit_out
);
    import satl_pkg::*;

    logic [2:0]          ctrl;
    logic [PKT_W-1:0]    request;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic [IRQ_W-1:0]    events;
    logic [IRQ_W-1:0]    next_irq_stat;
    logic                rx_mode;
    logic [TIMER_W-1:0]  timer;
    logic [CNT_W-1:0]    cnt;
    logic                awd;

    assign awd = ctrl[CTRL_AWD_BIT];

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl    <= CTRL_RESET;
            request <= '0;
            irq_mask <= '0;
        end else if (wr_in) begin
            if (addr_in == REG_CTRL)
                ctrl <= wdata_in[2:0];
            if (addr_in == REG_REQUEST)
                request <= wdata_in[PKT_W-1:0];
            if (addr_in == REG_IRQ_MASK)
                irq_mask <= wdata_in[IRQ_W-1:0];
        end
    end

    // Periodic request frames, only on AWD/4WD builds
    always_ff @(posedge clk_in) begin
        if (srst_in || !awd) begin
            timer          <= '0;
            cnt            <= '0;
            link.req_valid <= 1'b0;
            link.req_torque <= '0;
            link.req_act   <= 1'b0;
            link.req_cnt   <= '0;
            link.req_prot  <= '0;
        end else begin
            link.req_valid <= 1'b0;
            if (timer == TIMER_W'(SLOW_PERIOD - 1)) begin
                timer <= '0;
                link.req_valid  <= 1'b1;
                link.req_torque <= request[TORQUE_W-1:0];
                link.req_act    <= request[REQ_ACTIVE_BIT];
                link.req_cnt    <= cnt;
                link.req_prot   <= satl_protect(request, cnt, PROT_KEY)
                                   ^ {10'h000, ctrl[CTRL_BAD_PROT_BIT]};
                if (!ctrl[CTRL_HOLD_CNT_BIT])
                    cnt <= cnt + 1'b1;
            end else begin
                timer <= timer + 1'b1;
            end
        end
    end

    // Status frames are ignored unless configured for AWD/4WD
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_mode            <= MODE_INTERNAL;
            drive_off_lamp_out <= 1'b0;
            diff_limit_on_out  <= 1'b0;
            diff_limit_out     <= '0;
        end else if (!awd) begin
            rx_mode            <= MODE_INTERNAL;
            drive_off_lamp_out <= 1'b0;
            diff_limit_on_out  <= 1'b0;
        end else begin
            if (link.mode_valid)
                rx_mode <= link.mode_ext;
            if (link.stat_valid) begin
                drive_off_lamp_out <= link.inhibit;
                diff_limit_on_out  <= link.diff_act;
                diff_limit_out     <= link.diff_rpm;
            end
        end
    end

    always_comb begin
        events = '0;
        events[IRQ_MODE_BIT]    = awd && link.mode_valid && (link.mode_ext != rx_mode);
        events[IRQ_INHIBIT_BIT] = awd && link.stat_valid && link.inhibit && !drive_off_lamp_out;
        events[IRQ_DIFF_BIT]    = awd && link.stat_valid && (link.diff_act != diff_limit_on_out);
    end

    // Read clears, but a same-cycle event still lands
    always_comb begin
        if (rd_in && addr_in == REG_IRQ_STAT)
            next_irq_stat = events;
        else
            next_irq_stat = irq_stat | events;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in)
            irq_stat <= '0;
        else
            irq_stat <= next_irq_stat;
    end

    // Follows the next status so the line never lags a set that wins over a clear
    always_ff @(posedge clk_in) begin
        if (srst_in)
            irq_out <= 1'b0;
        else
            irq_out <= |(next_irq_stat & irq_mask);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            case (addr_in)
                REG_CTRL:     rdata_out <= {29'h0, ctrl};
                REG_REQUEST:  rdata_out <= {21'h0, request};
                REG_STATUS:   rdata_out <= {22'h0, drive_off_lamp_out, diff_limit_on_out,
                                            diff_limit_out, rx_mode};
                REG_IRQ_STAT: rdata_out <= {29'h0, irq_stat};
                REG_IRQ_MASK: rdata_out <= {29'h0, irq_mask};
                default:      rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end
endmodule

// ===== logic/satl_device.sv
// Transfer case controller end: status transmit and request checking
//
// Local design decisions: the strobed register port and the register addresses.
module satl_device #(
    parameter int unsigned MODE_PERIOD = satl_pkg::MODE_PERIOD_CYC,
    parameter int unsigned SLOW_PERIOD = satl_pkg::SLOW_PERIOD_CYC,
    parameter int unsigned WIN_X       = satl_pkg::WIN_X_DEF,
    parameter int unsigned WIN_Y       = satl_pkg::WIN_Y_DEF,
    parameter logic [7:0]  PROT_KEY    = satl_pkg::PROT_KEY_DEF
) (
    input  wire logic                          clk_in,
    input  wire logic                          srst_in,
    satl_if.device                             link,
    input  wire logic                          awd_fitted_in,
    input  wire logic                          electronic_clutch_in,
    input  wire logic                          inhibit_cond_in,
    input  wire logic [satl_pkg::DIFF_W-1:0]   diff_req_in,
    input  wire logic                          diff_req_act_in,
    input  wire logic                          drive_cycle_end_in,
    output logic                               torque_follow_out,
    output logic      [satl_pkg::TORQUE_W-1:0] torque_target_out,
    output logic                               rejected_out,
    output logic                               frame_err_out
);
    import satl_pkg::*;

    logic [TIMER_W-1:0]  mode_timer;
    logic [TIMER_W-1:0]  slow_timer;

    // Last accepted request data
    logic [TORQUE_W-1:0] acc_torque;
    logic                acc_act;

    // Rolling count tracking
    logic                cnt_seen;
    logic [CNT_W-1:0]    last_cnt;
    logic                cnt_err;
    logic                prot_err;
    logic                frame_err;

    // Sliding window state
    logic [WIN_Y-1:0]    err_hist;
    logic [WIN_Y-1:0]    next_err_hist;
    logic [7:0]          next_err_count;
    logic                rejected;
    logic                trip;
    logic                next_mode;

    // Frame checks
    always_comb begin
        prot_err  = link.req_prot !=
                    satl_protect({link.req_act, link.req_torque}, link.req_cnt, PROT_KEY);
        cnt_err   = cnt_seen && (link.req_cnt != last_cnt + 1'b1);
        frame_err = prot_err || cnt_err;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || !awd_fitted_in) begin
            cnt_seen <= 1'b0;
            last_cnt <= '0;
        end else if (link.req_valid) begin
            // Resync on whatever arrived, so a skipped count costs one error and a corrupted count costs two
            cnt_seen <= 1'b1;
            last_cnt <= link.req_cnt;
        end
    end

    // x-of-y window over the most recent Y frames
    always_comb begin
        next_err_hist  = {err_hist[WIN_Y-2:0], frame_err};
        next_err_count = '0;
        for (int i = 0; i < WIN_Y; i++) begin
            next_err_count = next_err_count + {7'h00, next_err_hist[i]};
        end
        trip = link.req_valid && (next_err_count >= 8'(WIN_X));
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || !awd_fitted_in)
            err_hist <= '0;
        else if (link.req_valid)
            err_hist <= next_err_hist;
    end

    // Latched until the driving cycle ends or reset; nothing else clears it
    always_ff @(posedge clk_in) begin
        if (srst_in || drive_cycle_end_in)
            rejected <= 1'b0;
        else if (awd_fitted_in && trip)
            rejected <= 1'b1;
    end

    // Accept only frames with a valid protection value while not rejected
    always_ff @(posedge clk_in) begin
        if (srst_in || !awd_fitted_in || drive_cycle_end_in) begin
            acc_torque <= '0;
            acc_act    <= 1'b0;
        end else if (link.req_valid && !prot_err && !rejected && !trip) begin
            acc_torque <= link.req_torque;
            acc_act    <= link.req_act;
        end else if (rejected || trip) begin
            acc_act    <= 1'b0;
        end
    end

    // Without electronic clutch coupling the mode is forced internal
    assign next_mode = (electronic_clutch_in && acc_act && !rejected) ? MODE_EXTERNAL
                                                                       : MODE_INTERNAL;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            torque_follow_out <= 1'b0;
            torque_target_out <= '0;
            rejected_out      <= 1'b0;
            frame_err_out     <= 1'b0;
        end else begin
            torque_follow_out <= next_mode;
            torque_target_out <= next_mode ? acc_torque : '0;
            rejected_out      <= rejected;
            frame_err_out     <= awd_fitted_in && link.req_valid && frame_err;
        end
    end

    // Fast status frame: control mode
    always_ff @(posedge clk_in) begin
        if (srst_in || !awd_fitted_in) begin
            mode_timer      <= '0;
            link.mode_valid <= 1'b0;
            link.mode_ext   <= MODE_INTERNAL;
        end else begin
            link.mode_valid <= 1'b0;
            if (mode_timer == TIMER_W'(MODE_PERIOD - 1)) begin
                mode_timer      <= '0;
                link.mode_valid <= 1'b1;
                link.mode_ext   <= next_mode;
            end else begin
                mode_timer <= mode_timer + 1'b1;
            end
        end
    end

    // Slow status frame: speed difference limit and temporary inhibit
    always_ff @(posedge clk_in) begin
        if (srst_in || !awd_fitted_in) begin
            slow_timer      <= '0;
            link.stat_valid <= 1'b0;
            link.diff_rpm   <= '0;
            link.diff_act   <= 1'b0;
            link.inhibit    <= 1'b0;
        end else begin
            link.stat_valid <= 1'b0;
            if (slow_timer == TIMER_W'(SLOW_PERIOD - 1)) begin
                slow_timer      <= '0;
                link.stat_valid <= 1'b1;
                link.diff_rpm   <= diff_req_in;
                link.diff_act   <= diff_req_act_in;
                // Recoverable condition only; fault storage plays no part
                link.inhibit    <= inhibit_cond_in;
            end else begin
                slow_timer <= slow_timer + 1'b1;
            end
        end
    end
endmodule

// ===== verif/satl_link_assertions.sv
// Checker for frame pulses, frame spacing and field holding on the link
module satl_link_assertions #(
    parameter int unsigned MODE_PERIOD = 20,
    parameter int unsigned SLOW_PERIOD = 50
) (
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic        mode_valid,
    input wire logic        mode_ext,
    input wire logic        stat_valid,
    input wire logic [6:0]  diff_rpm,
    input wire logic        diff_act,
    input wire logic        inhibit,
    input wire logic        req_valid,
    input wire logic [9:0]  req_torque,
    input wire logic        req_act,
    input wire logic [1:0]  req_cnt,
    input wire logic [10:0] req_prot
);
    logic [7:0] mode_gap;
    logic [7:0] req_gap;
    logic [1:0] seen;

    // Gaps only count once a first frame was seen, so reset needs no clear
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            seen <= 2'h0;
        end else begin
            seen <= seen | {req_valid, mode_valid};
        end
        mode_gap <= mode_valid ? 8'h0 : mode_gap + 8'h1;
        req_gap <= req_valid ? 8'h0 : req_gap + 8'h1;
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);

    a_mode_one_shot: assert property (mode_valid |=> !mode_valid [*8])
        else $error("mode frame pulse too long");
    a_stat_one_shot: assert property (stat_valid |=> !stat_valid [*8])
        else $error("status frame pulse too long");
    a_req_one_shot: assert property (req_valid |=> !req_valid [*8])
        else $error("request frame pulse too long");
    a_mode_spacing: assert property (mode_valid && seen[0] |-> mode_gap == 8'(MODE_PERIOD - 1))
        else $error("mode frame spacing wrong");
    a_req_spacing: assert property (req_valid && seen[1] |-> req_gap == 8'(SLOW_PERIOD - 1))
        else $error("request frame spacing wrong");
    a_req_fields_hold: assert property (!req_valid |-> $stable({req_torque, req_act, req_cnt, req_prot}))
        else $error("request fields moved between frames");
    a_stat_fields_hold: assert property (!stat_valid && !mode_valid |-> $stable({diff_rpm, diff_act, inhibit, mode_ext}))
        else $error("status fields moved between frames");
    a_prot_in_range: assert property (req_valid |-> req_prot[10:8] == 3'h0)
        else $error("protection value above 255");
endmodule

// ===== verif/tb_secondary_axle_torque_link.sv
// Bench joining both link ends, driving the register port and device inputs
module tb_secondary_axle_torque_link;
    timeunit 1ns;
    timeprecision 1ns;
    import satl_pkg::*;
    localparam int unsigned MP = 20;
    localparam int unsigned SP = 50;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        awd = 1'b0, clutch = 1'b0, inh = 1'b0, diff_on = 1'b0, cyc_end = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic [6:0]  diff_req = 7'h0, limit;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, seed = 32'hb172;
    logic [9:0]  target;
    logic [1:0]  last_cnt;
    logic        irq, lamp, limit_on, follow, rejected, frame_err;
    logic [31:0] exp_q[$];
    int          error_cnt = 0, total_checks = 0, mode_frames = 0, req_frames = 0, ferr = 0;
    satl_if link ();

    always #25 clk_in = ~clk_in;

    satl_device #(.MODE_PERIOD(MP), .SLOW_PERIOD(SP)) u_satl_device (
        .clk_in(clk_in), .srst_in(srst_in), .link(link), .awd_fitted_in(awd),
        .electronic_clutch_in(clutch), .inhibit_cond_in(inh), .diff_req_in(diff_req),
        .diff_req_act_in(diff_on), .drive_cycle_end_in(cyc_end), .torque_follow_out(follow),
        .torque_target_out(target), .rejected_out(rejected), .frame_err_out(frame_err));
    satl_chassis #(.SLOW_PERIOD(SP)) u_satl_chassis (
        .clk_in(clk_in), .srst_in(srst_in), .link(link), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq), .drive_off_lamp_out(lamp),
        .diff_limit_on_out(limit_on), .diff_limit_out(limit));
    satl_link_assertions #(.MODE_PERIOD(MP), .SLOW_PERIOD(SP)) u_satl_link_assertions (
        .clk_in(clk_in), .srst_in(srst_in), .mode_valid(link.mode_valid),
        .mode_ext(link.mode_ext), .stat_valid(link.stat_valid), .diff_rpm(link.diff_rpm),
        .diff_act(link.diff_act), .inhibit(link.inhibit), .req_valid(link.req_valid),
        .req_torque(link.req_torque), .req_act(link.req_act), .req_cnt(link.req_cnt),
        .req_prot(link.req_prot));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Each access waits one edge first, so strobes never get two values in one step
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
    endtask

    // Waits for a request frame; good frames are checked field by field on the wire
    task automatic wait_frame(input bit good, input logic [10:0] pkt);
        logic [7:0] sum;
        logic [1:0] nc;
        int         n;
        n = 0;
        while (link.req_valid !== 1'b1 && n < 4 * SP) begin
            @(posedge clk_in);
            n++;
        end
        chk("request frame", 1, link.req_valid);
        nc = last_cnt + 2'h1;
        sum = pkt[7:0] + {5'h0, pkt[10:8]} + {6'h0, nc} + PROT_KEY_DEF;
        if (good) begin
            chk("request fields", pkt, {link.req_act, link.req_torque});
            chk("rolling count", nc, link.req_cnt);
            chk("protection", {3'h0, sum}, link.req_prot);
        end
        tick(3);
    endtask

    always @(posedge clk_in) begin
        if (link.mode_valid === 1'b1) mode_frames++;
        if (link.req_valid === 1'b1) req_frames++;
        if (link.req_valid === 1'b1) last_cnt <= link.req_cnt;
        if (frame_err === 1'b1) ferr++;
        if (rd_d) chk("read data", exp_q.pop_front(), rdata);
        rd_d <= rd;
    end

    initial begin
        tick(20000);
        error_cnt++;
        $display("unexpected hang: watchdog expired");
        test_done();
    end

    initial begin
        logic [9:0] t;
        logic [9:0] tg;
        logic [6:0] d;
        logic [7:0] regs[6];
        int         base;
        regs = '{REG_CTRL, REG_REQUEST, REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK, 8'h14};
        tick(5);
        srst_in <= 1'b0;
        tick(200);
        chk("mode frames", 0, mode_frames);
        chk("request frames", 0, req_frames);
        foreach (regs[i]) rd_reg(regs[i], 32'h0);
        $display("test silent_link done");

        seed = xs(seed);
        t = seed[9:0];
        d = seed[22:16];
        diff_req <= d;
        diff_on <= 1'b1;
        inh <= 1'b1;
        clutch <= 1'b1;
        awd <= 1'b1;
        wr_reg(REG_IRQ_MASK, 32'h7);
        wr_reg(REG_REQUEST, {21'h0, 1'b1, t});
        wr_reg(REG_CTRL, 32'h1);
        rd_reg(REG_REQUEST, {21'h0, 1'b1, t});
        wait_frame(1'b0, 11'h0);
        chk("follow", 1, follow);
        chk("target", t, target);
        tick(120);
        rd_reg(REG_STATUS, {22'h0, 2'h3, d, 1'b1});
        chk("lamp", 1, lamp);
        chk("limit on", 1, limit_on);
        chk("limit", d, limit);
        chk("irq", 1, irq);
        rd_reg(REG_IRQ_STAT, 32'h7);
        rd_reg(REG_IRQ_STAT, 32'h0);
        tick(2);
        chk("irq", 0, irq);
        $display("test status_report done");

        wr_reg(REG_IRQ_MASK, 32'h0);
        inh <= 1'b0;
        tick(60);
        inh <= 1'b1;
        tick(60);
        chk("irq", 0, irq);
        wr_reg(REG_IRQ_MASK, 32'h2);
        tick(2);
        chk("irq", 1, irq);
        rd_reg(REG_IRQ_STAT, 32'h2);
        tick(2);
        chk("irq", 0, irq);
        $display("test irq_mask done");

        clutch <= 1'b0;
        tick(60);
        chk("follow", 0, follow);
        rd_reg(REG_STATUS, {22'h0, 2'h3, d, 1'b0});
        clutch <= 1'b1;
        tick(60);
        rd_reg(REG_IRQ_STAT, 32'h1);
        chk("follow", 1, follow);
        $display("test internal_mode done");

        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            t = (i == 3) ? 10'h3ff : seed[9:0];
            wr_reg(REG_REQUEST, {21'h0, i != 2, t});
            wait_frame(1'b1, {i != 2, t});
            chk("follow", i != 2, follow);
            chk("target", (i != 2) ? t : 10'h0, target);
        end
        tg = t;
        chk("frame errors", 0, ferr);
        $display("test torque_requests done");

        base = ferr;
        wr_reg(REG_CTRL, 32'h3);
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            wr_reg(REG_REQUEST, {21'h0, 1'b1, seed[9:0]});
            wait_frame(1'b0, 11'h0);
            chk("target kept", tg, target);
            chk("rejected", 0, rejected);
        end
        wr_reg(REG_CTRL, 32'h5);
        // The first held frame still carries a fresh count; the repeat comes next
        wait_frame(1'b0, 11'h0);
        wait_frame(1'b0, 11'h0);
        chk("frame errors", base + 3, ferr);
        chk("rejected", 1, rejected);
        chk("follow", 0, follow);
        wr_reg(REG_CTRL, 32'h1);
        wait_frame(1'b0, 11'h0);
        chk("rejected", 1, rejected);
        chk("target", 0, target);
        cyc_end <= 1'b1;
        tick(1);
        cyc_end <= 1'b0;
        tick(3);
        chk("rejected", 0, rejected);
        $display("test window_reject done");
        test_done();
    end
endmodule
